// ---- shared/port_standby_pkg.sv ----
// constants and types for the nibble ports and the standby controller
// assumes the instruction sequencer decodes halt/stop and drives the data-memory strobes
//
// Contract
// - port direction is per nibble; input after reset; output sticks until reset or stop 0000B
// - writing 71H loads the open-drain latch and turns that port to output
// - open-drain latch bit of 1 floats the pin so it can be read
// - open-drain latch bit 3 is absent: writes dropped, reads give 0
// - writing 72H loads port C latch and turns port C to output
// - writing 73H loads port D latch and turns port D to output
// - port reads return synchronised pin levels, never the latch, latch untouched
// - halt freezes the program counter while the oscillator keeps running
// - halt ended by halt wake rising edge resumes at once, no settling
// - reset in halt or stop is an ordinary reset restarting at 0H
// - stop disables the oscillator; stop wake rising edge resumes after stop
// - halt select 0 always enters halt; only reset ends it
// - halt select 1 enters only if halt wake pin low; edge or reset ends
// - stop select 0 resets peripherals, enters stop; only reset ends it
// - stop select 1 enters only if stop wake pin low; edge or reset ends
// - halt or stop 0001B keeps counter, memory, status word, latches, directions
// - stop 0000B clears counter and status word; latches kept; all pins input
// - after stop release or reset release wait eight clocks before running
`default_nettype none

package port_standby_pkg;
   localparam int            ADDR_W        = 7;
   localparam logic [6:0]    ADDR_PORT_B   = 7'h71;
   localparam logic [6:0]    ADDR_PORT_C   = 7'h72;
   localparam logic [6:0]    ADDR_PORT_D   = 7'h73;
   localparam int            OD_BITS       = 3;
   localparam int            NIB_BITS      = 4;
   localparam int            HALT_WAKE_BIT = 0;
   localparam int            STOP_WAKE_BIT = 1;
   localparam int            SEL_BIT       = 0;
   localparam int            SETTLE_CYCLES = 8;
   localparam logic [3:0]    SETTLE_LAST   = 4'(SETTLE_CYCLES - 1);
   localparam logic          DIR_RESET     = 1'b0;

   typedef enum logic [1:0] {ST_SETTLE, ST_RUN, ST_HALT, ST_STOP} state_t;
endpackage

`default_nettype wire

// ---- hw/pin_sync.sv ----
// two-flop synchroniser with a third stage for rising-edge detection
// assumes inputs are asynchronous pins; clk is the free-running root clock
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 11
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   initial begin
      if (WIDTH < 1) $error("pin_sync needs WIDTH >= 1");
   end

   // first stage is read only by the second
   // reset to the idle-high level of the wake pins, so no false rise follows reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '1;
         sync_q <= '1;
         prev_q <= '1;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;
endmodule

`default_nettype wire

// ---- hw/port_standby_ctrl.sv ----
// three nibble ports and the halt/stop standby controller
// assumes the sequencer gives one-cycle strobes and obeys hold_pc and run
`default_nettype none

module port_standby_ctrl (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // data-memory access from the sequencer
   input  wire logic                 mem_wr,
   input  wire logic                 mem_rd,
   input  wire logic [6:0]           mem_addr,
   input  wire logic [3:0]           mem_wdata,
   output logic      [3:0]           mem_rdata,
   output logic                      mem_rd_valid,
   // standby instructions from the sequencer
   input  wire logic                 halt_req,
   input  wire logic                 stop_req,
   input  wire logic [3:0]           standby_operand,
   // core control
   output logic                      hold_pc,
   output logic                      run,
   output logic                      osc_enable,
   output logic                      pc_clear,
   output logic                      psw_clear,
   // open-drain port: bit0 halt_wake_pin, bit1 stop_wake_pin, bit2 open_drain_bit2
   input  wire logic [2:0]           port_b_in,
   output logic      [2:0]           port_b_out,
   output logic      [2:0]           port_b_oe,
   // push-pull ports
   input  wire logic [3:0]           push_pull_port_c_in,
   output logic      [3:0]           push_pull_port_c_out,
   output logic      [3:0]           push_pull_port_c_oe,
   input  wire logic [3:0]           push_pull_port_d_in,
   output logic      [3:0]           push_pull_port_d_out,
   output logic      [3:0]           push_pull_port_d_oe
);
   localparam int PIN_W = port_standby_pkg::OD_BITS + 2 * port_standby_pkg::NIB_BITS;

   port_standby_pkg::state_t state_q;
   port_standby_pkg::state_t state_d;

   logic [2:0]       open_drain_port_latch_q;
   logic [3:0]       push_pull_port_c_latch_q;
   logic [3:0]       push_pull_port_d_latch_q;
   logic             dir_b_q;
   logic             dir_c_q;
   logic             dir_d_q;
   logic             halt_sel_q;
   logic             stop_sel_q;
   logic [3:0]       settle_cnt_q;
   logic [3:0]       mem_rdata_q;
   logic             mem_rd_valid_q;
   logic             pc_clear_q;
   logic             psw_clear_q;
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_lvl;
   logic [PIN_W-1:0] pins_rise;
   logic [2:0]       pin_b_lvl;
   logic [3:0]       pin_c_lvl;
   logic [3:0]       pin_d_lvl;
   logic             halt_wake_lvl;
   logic             stop_wake_lvl;
   logic             halt_wake_rise;
   logic             stop_wake_rise;
   logic             in_run;
   logic             wr_b;
   logic             wr_c;
   logic             wr_d;
   logic             stop_clear;

   function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] b);
      return a == b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin sampling

   assign pins_raw = {push_pull_port_d_in, push_pull_port_c_in, port_b_in};

   pin_sync #(
      .WIDTH (PIN_W)
   ) u_pin_sync (
      .clk    (clk),
      .rst_n  (rst_n),
      .pin_in (pins_raw),
      .level  (pins_lvl),
      .rise   (pins_rise)
   );

   assign pin_b_lvl      = pins_lvl[2:0];
   assign pin_c_lvl      = pins_lvl[6:3];
   assign pin_d_lvl      = pins_lvl[10:7];
   assign halt_wake_lvl  = pins_lvl[port_standby_pkg::HALT_WAKE_BIT];
   assign stop_wake_lvl  = pins_lvl[port_standby_pkg::STOP_WAKE_BIT];
   assign halt_wake_rise = pins_rise[port_standby_pkg::HALT_WAKE_BIT];
   assign stop_wake_rise = pins_rise[port_standby_pkg::STOP_WAKE_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // standby sequencing

   assign in_run = (state_q == port_standby_pkg::ST_RUN);

   // only operand bit 0 is looked at; upper bits are the program's duty
   // halt wins over a simultaneous stop, so no clear then
   assign stop_clear = in_run && stop_req && !halt_req
                       && !standby_operand[port_standby_pkg::SEL_BIT];

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         port_standby_pkg::ST_SETTLE: begin
            if (settle_cnt_q == port_standby_pkg::SETTLE_LAST) begin
               state_d = port_standby_pkg::ST_RUN;
            end
         end
         port_standby_pkg::ST_RUN: begin
            if (halt_req) begin
               if (!standby_operand[port_standby_pkg::SEL_BIT] || !halt_wake_lvl) begin
                  state_d = port_standby_pkg::ST_HALT;
               end
            end else if (stop_req) begin
               if (!standby_operand[port_standby_pkg::SEL_BIT] || !stop_wake_lvl) begin
                  state_d = port_standby_pkg::ST_STOP;
               end
            end
         end
         port_standby_pkg::ST_HALT: begin
            if (halt_sel_q && halt_wake_rise) begin
               state_d = port_standby_pkg::ST_RUN;
            end
         end
         port_standby_pkg::ST_STOP: begin
            if (stop_sel_q && stop_wake_rise) begin
               state_d = port_standby_pkg::ST_SETTLE;
            end
         end
      endcase
   end

   // reset from any mode lands in settle, then runs from 0H
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= port_standby_pkg::ST_SETTLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_cnt_q <= 4'h0;
      end else if (state_q == port_standby_pkg::ST_SETTLE) begin
         settle_cnt_q <= settle_cnt_q + 4'h1;
      end else begin
         settle_cnt_q <= 4'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         halt_sel_q <= 1'b0;
         stop_sel_q <= 1'b0;
      end else if (in_run) begin
         halt_sel_q <= standby_operand[port_standby_pkg::SEL_BIT];
         stop_sel_q <= standby_operand[port_standby_pkg::SEL_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_clear_q  <= 1'b0;
         psw_clear_q <= 1'b0;
      end else begin
         pc_clear_q  <= stop_clear;
         psw_clear_q <= stop_clear;
      end
   end

   // counter frozen in every non-run state; oscillator off only in stop
   assign hold_pc    = !in_run;
   assign run        = in_run;
   assign osc_enable = (state_q != port_standby_pkg::ST_STOP);
   assign pc_clear   = pc_clear_q;
   assign psw_clear  = psw_clear_q;

   ////////////////////////////////////////////////////////////////////////////////
   // port latches and directions

   assign wr_b = in_run && mem_wr && addr_hit(mem_addr, port_standby_pkg::ADDR_PORT_B);
   assign wr_c = in_run && mem_wr && addr_hit(mem_addr, port_standby_pkg::ADDR_PORT_C);
   assign wr_d = in_run && mem_wr && addr_hit(mem_addr, port_standby_pkg::ADDR_PORT_D);

   // latch data has no reset: its contents survive reset and stop
   always_ff @(posedge clk) begin
      if (wr_b) begin
         open_drain_port_latch_q <= mem_wdata[2:0];
      end
      if (wr_c) begin
         push_pull_port_c_latch_q <= mem_wdata;
      end
      if (wr_d) begin
         push_pull_port_d_latch_q <= mem_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dir_b_q <= port_standby_pkg::DIR_RESET;
         dir_c_q <= port_standby_pkg::DIR_RESET;
         dir_d_q <= port_standby_pkg::DIR_RESET;
      end else if (stop_clear) begin
         dir_b_q <= port_standby_pkg::DIR_RESET;
         dir_c_q <= port_standby_pkg::DIR_RESET;
         dir_d_q <= port_standby_pkg::DIR_RESET;
      end else begin
         dir_b_q <= dir_b_q | wr_b;
         dir_c_q <= dir_c_q | wr_c;
         dir_d_q <= dir_d_q | wr_d;
      end
   end

   // open drain only ever pulls low; a latched 1 floats the pin
   assign port_b_out = 3'h0;
   assign port_b_oe  = dir_b_q ? ~open_drain_port_latch_q : 3'h0;

   // data gated by direction so unwritten latches never reach a pin
   assign push_pull_port_c_out = dir_c_q ? push_pull_port_c_latch_q : 4'h0;
   assign push_pull_port_c_oe  = {4{dir_c_q}};
   assign push_pull_port_d_out = dir_d_q ? push_pull_port_d_latch_q : 4'h0;
   assign push_pull_port_d_oe  = {4{dir_d_q}};

   ////////////////////////////////////////////////////////////////////////////////
   // read path: pins, not latches

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rdata_q    <= 4'h0;
         mem_rd_valid_q <= 1'b0;
      end else begin
         mem_rd_valid_q <= mem_rd;
         if (!mem_rd) begin
            mem_rdata_q <= 4'h0;
         end else if (addr_hit(mem_addr, port_standby_pkg::ADDR_PORT_B)) begin
            mem_rdata_q <= {1'b0, pin_b_lvl};
         end else if (addr_hit(mem_addr, port_standby_pkg::ADDR_PORT_C)) begin
            mem_rdata_q <= pin_c_lvl;
         end else if (addr_hit(mem_addr, port_standby_pkg::ADDR_PORT_D)) begin
            mem_rdata_q <= pin_d_lvl;
         end else begin
            mem_rdata_q <= 4'h0;
         end
      end
   end

   assign mem_rdata    = mem_rdata_q;
   assign mem_rd_valid = mem_rd_valid_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_settle_entry;
      state_q == port_standby_pkg::ST_SETTLE && $past(state_q) != port_standby_pkg::ST_SETTLE;
   endsequence

   sequence s_held_eight;
      hold_pc [*8] ##1 run;
   endsequence

   chk_dir_sticky:
      assert property ((dir_c_q && !stop_clear) |=> dir_c_q)
      else $error("port direction fell back without reset");

   chk_b_write:
      assert property (wr_b |=> dir_b_q && open_drain_port_latch_q == $past(mem_wdata[2:0]))
      else $error("open-drain write not latched");

   chk_od_float:
      assert property ((dir_b_q && open_drain_port_latch_q[0]) |-> !port_b_oe[0])
      else $error("latched one still pulls pin low");

   chk_b3_zero:
      assert property ((mem_rd && addr_hit(mem_addr, port_standby_pkg::ADDR_PORT_B))
                       |=> mem_rd_valid && !mem_rdata[3])
      else $error("absent bit 3 read as one");

   chk_c_write:
      assert property (wr_c |=> push_pull_port_c_oe == 4'hF
                       && push_pull_port_c_out == $past(mem_wdata))
      else $error("port C write not driven");

   chk_d_write:
      assert property (wr_d |=> push_pull_port_d_oe == 4'hF
                       && push_pull_port_d_out == $past(mem_wdata))
      else $error("port D write not driven");

   chk_read_pins:
      assert property ((mem_rd && addr_hit(mem_addr, port_standby_pkg::ADDR_PORT_C))
                       |=> mem_rdata == $past(pin_c_lvl) && $stable(push_pull_port_c_latch_q))
      else $error("read did not return pin levels");

   chk_halt_osc:
      assert property (state_q == port_standby_pkg::ST_HALT |-> osc_enable && hold_pc)
      else $error("halt stopped oscillator or counter ran");

   chk_halt_wake:
      assert property ((state_q == port_standby_pkg::ST_HALT && halt_sel_q && halt_wake_rise)
                       |=> run)
      else $error("halt wake did not resume at once");

   chk_stop_osc:
      assert property (state_q == port_standby_pkg::ST_STOP |-> !osc_enable)
      else $error("oscillator running in stop");

   chk_halt0_stuck:
      assert property ((state_q == port_standby_pkg::ST_HALT && !halt_sel_q) |=>
                       state_q == port_standby_pkg::ST_HALT)
      else $error("unconditional halt left without reset");

   chk_halt1_skip:
      assert property ((in_run && halt_req && standby_operand[0] && halt_wake_lvl) |=> run)
      else $error("halt entered with wake pin high");

   chk_stop0_clear:
      assert property (stop_clear |=> pc_clear && psw_clear && !dir_b_q && !dir_c_q
                       && state_q == port_standby_pkg::ST_STOP)
      else $error("stop 0000B did not clear state");

   chk_stop1_skip:
      assert property ((in_run && !halt_req && stop_req && standby_operand[0] && stop_wake_lvl)
                       |=> run)
      else $error("stop entered with wake pin high");

   chk_keep_latch:
      assert property (state_q == port_standby_pkg::ST_HALT |=>
                       $stable(push_pull_port_d_latch_q) && $stable(dir_d_q))
      else $error("latch or direction changed in halt");

   chk_settle_wait:
      assert property (s_settle_entry |-> s_held_eight)
      else $error("execution did not wait eight clocks");
endmodule

`default_nettype wire

// ---- tb/pin_model.sv ----
// external circuits on the port pins: a soft outside drive on every pin
// assumes the bench sets the outside levels; a pin the device drives wins over them
`default_nettype none

module pin_model (
   input  wire logic [2:0] port_b_out,
   input  wire logic [2:0] port_b_oe,
   input  wire logic [2:0] ext_b,
   output logic      [2:0] port_b_in,
   input  wire logic [3:0] c_out,
   input  wire logic [3:0] c_oe,
   input  wire logic [3:0] ext_c,
   output logic      [3:0] c_in,
   input  wire logic [3:0] d_out,
   input  wire logic [3:0] d_oe,
   input  wire logic [3:0] ext_d,
   output logic      [3:0] d_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // open drain: a released bit shows only the outside level
   assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & ext_b);
   assign c_in      = (c_oe & c_out) | (~c_oe & ext_c);
   assign d_in      = (d_oe & d_out) | (~d_oe & ext_d);
endmodule

`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the nibble ports and the standby controller
// assumes pin_model resolves every pin from the device outputs and the outside levels
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [6:0] a;
      logic [3:0] w, x, rd, oe, out;
   } row_t;

   logic       clk, rst_n, mem_wr, mem_rd, halt_req, stop_req;
   logic       rd_valid, hold_pc, run, osc_enable, pc_clear, psw_clear;
   logic [6:0] mem_addr;
   logic [3:0] mem_wdata, rdata, op, ext_c, ext_d, c_in, c_out, c_oe, d_in, d_out, d_oe;
   logic [2:0] ext_b, b_in, b_out, b_oe;
   logic [3:0] d;
   logic [7:0] ob;
   int         errors, check_count, cnt;

   // last row is unmapped: nothing moves, port D is watched instead
   row_t rows[5] = '{
      '{7'h71, 4'h2, 4'h5, 4'h0, 4'h5, 4'h0},
      '{7'h71, 4'hF, 4'h6, 4'h6, 4'h0, 4'h0},
      '{7'h72, 4'hA, 4'h5, 4'hA, 4'hF, 4'hA},
      '{7'h73, 4'h3, 4'hC, 4'h3, 4'hF, 4'h3},
      '{7'h70, 4'h9, 4'h0, 4'h0, 4'hF, 4'h3}};

   port_standby_ctrl DUT (.clk(clk), .rst_n(rst_n), .mem_wr(mem_wr), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(rdata),
      .mem_rd_valid(rd_valid), .halt_req(halt_req), .stop_req(stop_req),
      .standby_operand(op), .hold_pc(hold_pc), .run(run), .osc_enable(osc_enable),
      .pc_clear(pc_clear), .psw_clear(psw_clear), .port_b_in(b_in), .port_b_out(b_out),
      .port_b_oe(b_oe), .push_pull_port_c_in(c_in), .push_pull_port_c_out(c_out),
      .push_pull_port_c_oe(c_oe), .push_pull_port_d_in(d_in),
      .push_pull_port_d_out(d_out), .push_pull_port_d_oe(d_oe));

   pin_model pins (.port_b_out(b_out), .port_b_oe(b_oe), .ext_b(ext_b), .port_b_in(b_in),
      .c_out(c_out), .c_oe(c_oe), .ext_c(ext_c), .c_in(c_in),
      .d_out(d_out), .d_oe(d_oe), .ext_d(ext_d), .d_in(d_in));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("tests done: %0d checks, %0d mismatches", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [6:0] a, input logic [3:0] w);
      @(posedge clk);
      mem_wr <= 1'b1;
      mem_addr <= a;
      mem_wdata <= w;
      @(posedge clk);
      mem_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [6:0] a, output logic [3:0] v);
      @(posedge clk);
      mem_rd <= 1'b1;
      mem_addr <= a;
      @(posedge clk);
      mem_rd <= 1'b0;
      #1;
      check("rd_valid", 4'(rd_valid), 4'h1);
      v = rdata;
   endtask

   task automatic sb(input logic h, input logic s, input logic [3:0] o);
      @(posedge clk);
      halt_req <= h;
      stop_req <= s;
      op <= o;
      @(posedge clk);
      halt_req <= 1'b0;
      stop_req <= 1'b0;
      #1;
   endtask

   // bounded wait on run (osc=0) or osc_enable (osc=1)
   task automatic wait_hi(input logic osc, input int lim, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (((osc ? osc_enable : run) !== 1'b1) && n < lim);
      if ((osc ? osc_enable : run) !== 1'b1) begin
         errors++;
         $display("mismatch wait expected 1 seen 0");
         finish_test();
      end
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      cyc(8);
      #1;
      check("rst_hold", {run, hold_pc, osc_enable, 1'b0}, 4'h6);
      check("rst_oe", c_oe | d_oe | 4'(b_oe), 4'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      cyc(7);
      #1;
      check("settle_run", 4'(run), 4'h0);
      @(posedge clk);
      #1;
      check("settle_end", 4'(run), 4'h1);
      $display("reset test done");
   endtask

   function automatic logic [7:0] obs(input logic [6:0] a);
      case (a)
         port_standby_pkg::ADDR_PORT_B: return {1'b0, b_oe, 1'b0, b_out};
         port_standby_pkg::ADDR_PORT_C: return {c_oe, c_out};
         default: return {d_oe, d_out};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, mem_wr, mem_rd, halt_req, stop_req} = '0;
      {mem_addr, mem_wdata, op} = '0;
      {ext_b, ext_c, ext_d} = {3'h7, 4'h9, 4'h0};
      errors = 0;
      check_count = 0;
      cyc(8);
      rst_n <= 1'b1;
      cyc(9);
      rd(7'h72, d);
      check("input_mode_rd", d, 4'h9);
      foreach (rows[i]) begin
         @(posedge clk);
         if (rows[i].a == 7'h71) ext_b <= rows[i].x[2:0];
         if (rows[i].a == 7'h72) ext_c <= rows[i].x;
         wr(rows[i].a, rows[i].w);
         cyc(3);
         rd(rows[i].a, d);
         check("rdata", d, rows[i].rd);
         ob = obs(rows[i].a);
         check("oe", ob[7:4], rows[i].oe);
         check("out", ob[3:0], rows[i].out);
         $display("row %0d done", i);
      end
      // wake levels high: select 1 entries must be refused
      ext_b <= 3'h7;
      cyc(3);
      sb(1'b1, 1'b0, 4'h1);
      check("halt_refused", 4'(run), 4'h1);
      sb(1'b0, 1'b1, 4'h1);
      check("stop_refused", 4'(osc_enable & run), 4'h1);
      ext_b <= 3'h4;
      cyc(3);
      sb(1'b1, 1'b0, 4'h1);
      check("halt_entry", {run, hold_pc, osc_enable, 1'b0}, 4'h6);
      wr(7'h72, 4'h5);
      check("halt_latch", c_out, 4'hA);
      @(posedge clk);
      ext_b <= 3'h5;
      wait_hi(1'b0, 6, cnt);
      check("halt_no_settle", 4'(cnt <= 5), 4'h1);
      $display("halt wake test done");
      sb(1'b0, 1'b1, 4'h1);
      check("stop_entry", {osc_enable, run, 2'h0}, 4'h0);
      check("stop_dir", c_oe, 4'hF);
      @(posedge clk);
      ext_b <= 3'h7;
      wait_hi(1'b1, 6, cnt);
      wait_hi(1'b0, 12, cnt);
      check("stop_settle", 4'(cnt), 4'h8);
      $display("stop wake test done");
      ext_b <= 3'h6;
      cyc(3);
      sb(1'b1, 1'b0, 4'h0);
      ext_b <= 3'h7;
      cyc(6);
      #1;
      check("halt0_held", 4'(run), 4'h0);
      do_reset();
      wr(7'h72, 4'hA);
      ext_b <= 3'h5;
      cyc(3);
      sb(1'b0, 1'b1, 4'h0);
      check("stop0_clear", {pc_clear, psw_clear, osc_enable, 1'b0}, 4'hC);
      check("stop0_dir", c_oe | d_oe | 4'(b_oe), 4'h0);
      @(posedge clk);
      #1;
      check("stop0_pulse", {pc_clear, psw_clear, 2'h0}, 4'h0);
      ext_b <= 3'h7;
      cyc(6);
      #1;
      check("stop0_held", 4'(osc_enable | run), 4'h0);
      do_reset();
      // halt and stop together: halt wins, nothing is cleared
      wr(7'h72, 4'hA);
      sb(1'b1, 1'b1, 4'h0);
      check("prio_halt", {run, pc_clear, psw_clear, osc_enable}, 4'h1);
      check("prio_dir", c_oe, 4'hF);
      $display("priority test done");
      finish_test();
   end
endmodule

`default_nettype wire
